//--- erbm_engine.v
// exception report engine: trigger capture, register file and modbus master sequencer
//
// Our own choices: strobed register access and the address map.
`default_nettype none
`include "erbm_map.vh"
// ============================================================
module erbm_engine (
  input  wire        CLK,
  input  wire        NRST,
  input  wire [7:0]  ADDR,
  input  wire [15:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [15:0] RDATA,
  input  wire [31:0] TRIG,
  input  wire [15:0] WATCH_VALUE,
  input  wire [15:0] TIME_NOW,
  input  wire [15:0] DATE_NOW,
  input  wire        LINK_BUSY,
  input  wire        MODEM_ATTACHED,
  input  wire        MORE_NUMBERS,
  input  wire        TX_READY,
  input  wire        RX_DONE,
  input  wire        RX_OK,
  input  wire        RX_UNEXPECTED,
  input  wire [6:0]  RX_EXC_CODE,
  input  wire        DRV_STOP,
  output reg         TX_START,
  output reg  [1:0]  TX_PORT,
  output reg  [7:0]  TX_SLAVE,
  output reg  [15:0] TX_REG,
  output reg  [13:0] TX_UNIT_ID,
  output reg  [5:0]  TX_EXC_NUM,
  output reg  [15:0] TX_VALUE,
  output reg  [15:0] TX_TIME,
  output reg  [15:0] TX_DATE,
  output reg         DIAL_NEXT
);

  // ============================================================
  // sequencer states
  // idle waits for a pending report with reporting switched on.
  // quiet counts milliseconds of silent carrier; any traffic restarts it.
  // hold adds the collision-avoidance delay; traffic sends us back to quiet.
  // send waits for the serial driver to take the request on an idle link.
  // wait counts the reply window and records the outcome as status.
  // broadcast skips wait, since no slave ever answers a broadcast.
  // limitation: the millisecond enable runs free, so every interval
  // may come out up to one millisecond short of its setting.
  // trade-off: a free divider saves a second counter per interval.
  localparam S_IDLE  = 3'h0;
  localparam S_QUIET = 3'h1;
  localparam S_HOLD  = 3'h2;
  localparam S_SEND  = 3'h3;
  localparam S_WAIT  = 3'h4;

  // ============================================================
  // configuration and captured report
  reg [13:0] unit_identifier_r;
  reg [1:0]  report_destination_port_r;
  reg [6:0]  report_error_status_r;
  reg [7:0]  target_slave_address_r;
  reg [13:0] target_start_register_r;
  reg [13:0] connect_try_count_r;
  reg [13:0] reply_timeout_ms_r;
  reg [13:0] carrier_quiet_time_r;
  reg [13:0] holding_time_r;
  reg        trig_cfg_ok_r;
  reg [31:0] trig_prev_r;
  reg [5:0]  exc_num_r;
  reg [15:0] exc_value_r;
  reg [15:0] exc_time_r;
  reg [15:0] exc_date_r;
  reg        pending_r;
  reg [2:0]  state_r;
  reg [15:0] ms_div_r;
  reg [13:0] ms_cnt_r;
  reg [13:0] tries_r;

  wire        ms_tick;
  wire [31:0] trig_rise;
  wire        report_on;
  wire        unlimited;
  wire        tries_left;

  // lowest-numbered new trigger wins; others in the same cycle are dropped
  // limitation: only one exception is stored, so simultaneous rises
  // on several trigger lines report just one of them.
  // the result is the line number plus one, so zero means none.
  function [5:0] first_set;
    input [31:0] v;
    integer i;
    begin
      first_set = 6'h00;
      for (i = 31; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = i[5:0] + 6'h01;
        end
      end
    end
  endfunction

  // clamp a written setting to its documented ceiling
  // out-of-range writes saturate rather than wrap, so a large value
  // never turns into a tiny interval by losing its upper bits.
  function [13:0] clamp14;
    input [15:0] v;
    input [13:0] lim;
    begin
      clamp14 = (v > {2'h0, lim}) ? lim : v[13:0];
    end
  endfunction

  assign ms_tick    = (ms_div_r == 16'h0000);
  assign trig_rise  = TRIG & ~trig_prev_r;
  assign report_on  = trig_cfg_ok_r && (unit_identifier_r != 14'h0000);
  // broadcast sends once, so try count does not apply
  assign unlimited  = (connect_try_count_r == 14'h0000);
  assign tries_left = unlimited || (tries_r < connect_try_count_r);

  // ============================================================
  // millisecond enable from the 40 MHz clock
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ms_div_r <= 16'h0000;
    end else if (ms_tick) begin
      // sized reload keeps the 32-bit arithmetic out of this register
      ms_div_r <= `ERBM_MS_RELOAD;
    end else begin
      ms_div_r <= ms_div_r - 16'h0001;
    end
  end

  // ============================================================
  // register writes, capture and send sequencer
  // strobes and send fields are registered here, so every output
  // comes straight from a flip-flop and never glitches.
  // writes land in the cycle after the strobe.
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      unit_identifier_r         <= `ERBM_RST_UNIT_ID;
      report_destination_port_r <= `ERBM_RST_DEST;
      report_error_status_r     <= `ERBM_RST_STATUS;
      target_slave_address_r    <= `ERBM_RST_SLAVE;
      target_start_register_r   <= `ERBM_RST_START;
      connect_try_count_r       <= `ERBM_RST_TRIES;
      reply_timeout_ms_r        <= `ERBM_RST_TIMEOUT;
      carrier_quiet_time_r      <= `ERBM_RST_QUIET;
      holding_time_r            <= `ERBM_RST_HOLD;
      trig_cfg_ok_r             <= 1'b0;
      trig_prev_r               <= 32'h00000000;
      exc_num_r                 <= 6'h00;
      exc_value_r               <= 16'h0000;
      exc_time_r                <= 16'h0000;
      exc_date_r                <= 16'h0000;
      pending_r                 <= 1'b0;
      state_r                   <= S_IDLE;
      ms_cnt_r                  <= 14'h0000;
      tries_r                   <= 14'h0000;
      TX_START                  <= 1'b0;
      TX_PORT                   <= 2'h0;
      TX_SLAVE                  <= 8'h00;
      TX_REG                    <= 16'h0000;
      TX_UNIT_ID                <= 14'h0000;
      TX_EXC_NUM                <= 6'h00;
      TX_VALUE                  <= 16'h0000;
      TX_TIME                   <= 16'h0000;
      TX_DATE                   <= 16'h0000;
      DIAL_NEXT                 <= 1'b0;
    end else begin
      TX_START  <= 1'b0;
      DIAL_NEXT <= 1'b0;
      trig_prev_r <= TRIG;
      // software writes
      if (WR) begin
        case (ADDR)
          `ERBM_A_UNIT_ID:     unit_identifier_r <= clamp14(WDATA, `ERBM_ID_MAX);
          `ERBM_A_DEST_PORT:   report_destination_port_r <= WDATA[1:0];
          `ERBM_A_SLAVE_ADDR:  target_slave_address_r <= (WDATA[7:0] > `ERBM_SLAVE_MAX) ?
                                 `ERBM_SLAVE_MAX : WDATA[7:0];
          `ERBM_A_START_REG:   target_start_register_r <= (WDATA == 16'h0000) ? 14'h0001 :
                                 clamp14(WDATA, `ERBM_ID_MAX);
          `ERBM_A_TRY_COUNT:   connect_try_count_r <= clamp14(WDATA, `ERBM_ID_MAX);
          `ERBM_A_TIMEOUT_MS:  reply_timeout_ms_r <= (WDATA == 16'h0000) ? 14'h0001 :
                                 clamp14(WDATA, `ERBM_ID_MAX);
          `ERBM_A_QUIET_MS:    carrier_quiet_time_r <= clamp14(WDATA, 14'h2710);
          `ERBM_A_HOLD_MS:     holding_time_r <= clamp14(WDATA, 14'h07d0);
          `ERBM_A_TRIG_CFG_OK: trig_cfg_ok_r <= WDATA[0];
          default: ;
        endcase
      end
      // a new exception replaces the stored one, even while sending
      // the capture branch wins over the sequencer in the same cycle,
      // so a report half way through its quiet time starts over.
      // the try counter is cleared, giving the new report a full set.
      // a poll of the exception registers always sees the newest one.
      if (report_on && (trig_rise != 32'h00000000)) begin
        exc_num_r   <= first_set(trig_rise);
        exc_value_r <= WATCH_VALUE;
        exc_time_r  <= TIME_NOW;
        exc_date_r  <= DATE_NOW;
        // stored for polling even when sending is off
        pending_r   <= (report_destination_port_r != 2'h0);
        tries_r     <= 14'h0000;
        state_r     <= S_IDLE;
      end else begin
        case (state_r)
          S_IDLE: begin
            if (pending_r && report_on) begin
              state_r  <= S_QUIET;
              ms_cnt_r <= 14'h0000;
            end
          end
          // any slave traffic restarts the quiet window
          S_QUIET: begin
            if (LINK_BUSY) begin
              ms_cnt_r <= 14'h0000;
            end else if (ms_cnt_r >= carrier_quiet_time_r) begin
              state_r  <= S_HOLD;
              ms_cnt_r <= 14'h0000;
            end else if (ms_tick) begin
              ms_cnt_r <= ms_cnt_r + 14'h0001;
            end
          end
          S_HOLD: begin
            if (LINK_BUSY) begin
              state_r  <= S_QUIET;
              ms_cnt_r <= 14'h0000;
            end else if (ms_cnt_r >= holding_time_r) begin
              state_r  <= S_SEND;
            end else if (ms_tick) begin
              ms_cnt_r <= ms_cnt_r + 14'h0001;
            end
          end
          S_SEND: begin
            if (TX_READY && !LINK_BUSY) begin
              TX_START   <= 1'b1;
              TX_PORT    <= report_destination_port_r;
              TX_SLAVE   <= target_slave_address_r;
              TX_REG     <= `ERBM_HREG_BASE + {2'h0, target_start_register_r};
              TX_UNIT_ID <= unit_identifier_r;
              TX_EXC_NUM <= exc_num_r;
              TX_VALUE   <= exc_value_r;
              TX_TIME    <= exc_time_r;
              TX_DATE    <= exc_date_r;
              tries_r    <= tries_r + 14'h0001;
              ms_cnt_r   <= 14'h0000;
              if (target_slave_address_r == 8'h00) begin
                // broadcast: no reply, no timeout
                report_error_status_r <= `ERBM_ST_OK;
                pending_r <= 1'b0;
                state_r   <= S_IDLE;
              end else begin
                state_r <= S_WAIT;
              end
            end
          end
          // reply window
          // priority: driver halt, unexpected, malformed, good reply, timeout.
          // a halted driver ends the report, as no reply can come any more.
          // malformed and unexpected replies leave the report pending,
          // so it is sent again after a fresh quiet and hold interval.
          // a timeout with tries left also resends; with none left, a modem
          // moves to its next number if one is left, and otherwise the failure is final.
          // hazard: a reply that lands in the timeout cycle counts as a reply.
          S_WAIT: begin
            if (ms_tick) begin
              ms_cnt_r <= ms_cnt_r + 14'h0001;
            end
            if (DRV_STOP) begin
              report_error_status_r <= `ERBM_ST_STOPPED;
              pending_r <= 1'b0;
              state_r   <= S_IDLE;
            end else if (RX_DONE && RX_UNEXPECTED) begin
              report_error_status_r <= `ERBM_ST_UNEXP;
              state_r <= S_IDLE;
            end else if (RX_DONE && !RX_OK) begin
              report_error_status_r <= `ERBM_ST_UNRECOG;
              state_r <= S_IDLE;
            end else if (RX_DONE) begin
              // code 0 success or driver exception 1..99
              report_error_status_r <= (RX_EXC_CODE > 7'h63) ? 7'h63 :
                                       RX_EXC_CODE;
              pending_r <= 1'b0;
              state_r   <= S_IDLE;
            end else if (ms_cnt_r >= reply_timeout_ms_r) begin
              state_r <= S_IDLE;
              if (tries_left) begin
                report_error_status_r <= `ERBM_ST_TIMEOUT;
              end else if (MODEM_ATTACHED && MORE_NUMBERS) begin
                report_error_status_r <= `ERBM_ST_NOCONN;
                DIAL_NEXT <= 1'b1;
                tries_r   <= 14'h0000;
              end else if (MODEM_ATTACHED) begin
                report_error_status_r <= `ERBM_ST_ALLFAIL;
                pending_r <= 1'b0;
              end else begin
                report_error_status_r <= `ERBM_ST_FAILTRY;
                pending_r <= 1'b0;
              end
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // read port, data one cycle after the strobe
  // read data fall back to zero outside the read slot, so a stale
  // value can never be mistaken for an answer by the bus master.
  // unmapped offsets read as zero and never stall the bus.
  // offset 14 shows the sequencer state, which is zero once idle.
  // the exception registers stay readable after a failed send.
  // trade-off: one registered mux instead of a combinational read path.
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        `ERBM_A_UNIT_ID:     RDATA <= {2'h0, unit_identifier_r};
        `ERBM_A_DEST_PORT:   RDATA <= {14'h0000, report_destination_port_r};
        `ERBM_A_ERR_STATUS:  RDATA <= {9'h000, report_error_status_r};
        `ERBM_A_SLAVE_ADDR:  RDATA <= {8'h00, target_slave_address_r};
        `ERBM_A_START_REG:   RDATA <= {2'h0, target_start_register_r};
        `ERBM_A_TRY_COUNT:   RDATA <= {2'h0, connect_try_count_r};
        `ERBM_A_TIMEOUT_MS:  RDATA <= {2'h0, reply_timeout_ms_r};
        `ERBM_A_QUIET_MS:    RDATA <= {2'h0, carrier_quiet_time_r};
        `ERBM_A_HOLD_MS:     RDATA <= {2'h0, holding_time_r};
        `ERBM_A_TRIG_CFG_OK: RDATA <= {15'h0000, trig_cfg_ok_r};
        `ERBM_A_EXC_NUM:     RDATA <= {10'h000, exc_num_r};
        `ERBM_A_EXC_VALUE:   RDATA <= exc_value_r;
        `ERBM_A_EXC_TIME:    RDATA <= exc_time_r;
        `ERBM_A_EXC_DATE:    RDATA <= exc_date_r;
        `ERBM_A_PENDING:     RDATA <= {13'h0000, state_r};
        default:             RDATA <= 16'h0000;
      endcase
    end else begin
      RDATA <= 16'h0000;
    end
  end

endmodule // erbm_engine
`default_nettype wire

//--- erbm_engine_chk.sv
// assertion checker for the exception report engine ports
`default_nettype none
module erbm_chk (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        LINK_BUSY,
  input wire logic        TX_READY,
  input wire logic        MODEM_ATTACHED,
  input wire logic        MORE_NUMBERS,
  input wire logic        TX_START,
  input wire logic [1:0]  TX_PORT,
  input wire logic [7:0]  TX_SLAVE,
  input wire logic [15:0] TX_REG,
  input wire logic [13:0] TX_UNIT_ID,
  input wire logic        DIAL_NEXT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // ============================================================
  // send strobe and the fields beside it
  AST_START_PULSE: assert property (TX_START |=> !TX_START [*2])
    else $error("send strobe not a lone pulse");
  AST_NO_PREEMPT: assert property (TX_START |-> $past(TX_READY) && !$past(LINK_BUSY))
    else $error("send started over busy link");
  AST_FIELDS_HOLD: assert property (!TX_START |-> $stable(TX_REG) && $stable(TX_SLAVE)
    && $stable(TX_PORT) && $stable(TX_UNIT_ID))
    else $error("send fields moved between sends");
  AST_START_FIELDS: assert property (TX_START |-> TX_PORT != 2'h0 && TX_UNIT_ID != 14'h0
    && TX_UNIT_ID <= 14'h270f)
    else $error("send with disabled port or unit id");
  AST_REG_RANGE: assert property (TX_START |-> TX_REG inside {[16'h9c41:16'hc34f]})
    else $error("target register out of range");
  AST_SLAVE_RANGE: assert property (TX_START |-> TX_SLAVE <= 8'hf7)
    else $error("slave address above 247");
  // ============================================================
  // dialling and read port
  AST_DIAL_PULSE: assert property (DIAL_NEXT |=> !DIAL_NEXT)
    else $error("dial strobe longer than one cycle");
  AST_DIAL_CAUSE: assert property (DIAL_NEXT |-> $past(MODEM_ATTACHED) && $past(MORE_NUMBERS))
    else $error("dial request without modem numbers");
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read slot");
  COV_SEND: cover property (TX_START && TX_SLAVE != 8'h00);
  COV_BCAST: cover property (TX_START && TX_SLAVE == 8'h00);
  COV_DIAL: cover property (DIAL_NEXT);
endmodule // erbm_chk
bind erbm_engine erbm_chk i_chk (.CLK(CLK), .NRST(NRST), .RD(RD), .RDATA(RDATA),
  .LINK_BUSY(LINK_BUSY), .TX_READY(TX_READY), .MODEM_ATTACHED(MODEM_ATTACHED),
  .MORE_NUMBERS(MORE_NUMBERS), .TX_START(TX_START), .TX_PORT(TX_PORT), .TX_SLAVE(TX_SLAVE),
  .TX_REG(TX_REG), .TX_UNIT_ID(TX_UNIT_ID), .DIAL_NEXT(DIAL_NEXT));
`default_nettype wire

//--- erbm_engine_tb.sv
// self-checking bench for the exception report engine
`default_nettype none
`include "erbm_map.vh"
module erbm_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, rd_d = 1'b0;
  logic        LINK_BUSY = 1'b0, MODEM_ATTACHED = 1'b0, MORE_NUMBERS = 1'b0;
  logic [7:0]  ADDR = 8'h00, delay = 8'h14, slave = 8'h00;
  logic [15:0] WDATA = 16'h0000, WATCH_VALUE = 16'h0000, TIME_NOW = 16'h0000;
  logic [15:0] DATE_NOW = 16'h0000, RDATA;
  logic [31:0] TRIG = 32'h0;
  logic [2:0]  mode = 3'h0;
  logic [6:0]  code = 7'h00, RX_EXC_CODE;
  logic [1:0]  port = 2'h0, TX_PORT;
  logic [13:0] start = 14'h0001, unit = 14'h0005, TX_UNIT_ID;
  logic        TX_READY, RX_DONE, RX_OK, RX_UNEXPECTED, DRV_STOP, TX_START, DIAL_NEXT;
  logic [7:0]  TX_SLAVE;
  logic [15:0] TX_REG, TX_VALUE, TX_TIME, TX_DATE;
  logic [5:0]  TX_EXC_NUM;
  logic [15:0] rd_q[$];
  logic [93:0] tx_q[$];
  int          error_cnt = 0, n_compared = 0, n_ans, i, s;
  always #12.5 CLK = ~CLK;
  erbm_engine i_dut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .TRIG(TRIG), .WATCH_VALUE(WATCH_VALUE), .TIME_NOW(TIME_NOW),
    .DATE_NOW(DATE_NOW), .LINK_BUSY(LINK_BUSY), .MODEM_ATTACHED(MODEM_ATTACHED),
    .MORE_NUMBERS(MORE_NUMBERS), .TX_READY(TX_READY), .RX_DONE(RX_DONE), .RX_OK(RX_OK),
    .RX_UNEXPECTED(RX_UNEXPECTED), .RX_EXC_CODE(RX_EXC_CODE), .DRV_STOP(DRV_STOP),
    .TX_START(TX_START), .TX_PORT(TX_PORT), .TX_SLAVE(TX_SLAVE), .TX_REG(TX_REG),
    .TX_UNIT_ID(TX_UNIT_ID), .TX_EXC_NUM(TX_EXC_NUM), .TX_VALUE(TX_VALUE),
    .TX_TIME(TX_TIME), .TX_DATE(TX_DATE), .DIAL_NEXT(DIAL_NEXT));
  erbm_far_end i_far (.CLK(CLK), .NRST(NRST), .TX_START(TX_START), .TX_SLAVE(TX_SLAVE),
    .mode(mode), .code(code), .delay(delay), .TX_READY(TX_READY), .RX_DONE(RX_DONE),
    .RX_OK(RX_OK), .RX_UNEXPECTED(RX_UNEXPECTED), .RX_EXC_CODE(RX_EXC_CODE),
    .DRV_STOP(DRV_STOP), .n_ans(n_ans));
  // ============================================================
  // reporting and comparison
  task automatic fail(input string msg);
    $display("CHECK FAILED %0t %s", $time, msg);
    error_cnt++;
  endtask
  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask
  task automatic cmp_tx(input logic [93:0] got, input logic [93:0] exp);
    n_compared++;
    if (got !== exp) fail($sformatf("send %h expected %h", got, exp));
  endtask
  task automatic wrap_up();
    if (rd_q.size() != 0 || tx_q.size() != 0) fail("notes left unchecked");
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ============================================================
  // bus master: one-cycle strobes, read data taken by the monitor
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    rd_q.push_back(e);
    @(posedge CLK);
    RD <= 1'b0;
  endtask
  task automatic cfg(input logic [1:0] p, input logic [7:0] sl, input logic [13:0] st);
    port  = p;
    slave = sl;
    start = st;
    wr(`ERBM_A_DEST_PORT, {14'h0, p});
    wr(`ERBM_A_SLAVE_ADDR, {8'h00, sl});
    wr(`ERBM_A_START_REG, {2'h0, st});
  endtask
  // raise one trigger and note the sends it should produce
  task automatic fire(input int b, input int sends);
    @(posedge CLK);
    WATCH_VALUE <= 16'($urandom);
    TIME_NOW    <= 16'($urandom);
    DATE_NOW    <= 16'($urandom);
    @(posedge CLK);
    TRIG <= 32'h1 << b;
    repeat (sends) tx_q.push_back({port, slave, `ERBM_HREG_BASE + {2'h0, start}, unit,
      6'(b + 1), WATCH_VALUE, TIME_NOW, DATE_NOW});
    @(posedge CLK);
    TRIG <= 32'h0;
  endtask
  // bounded wait: 0 replies reach n, 1 all noted sends seen, 2 dial strobe
  task automatic wait_until(input int kind, input int n);
    int k;
    k = 0;
    while (!((kind == 0 && n_ans >= n) || (kind == 1 && tx_q.size() == 0)
             || (kind == 2 && DIAL_NEXT === 1'b1))) begin
      @(posedge CLK);
      k++;
      if (k > 90000) begin
        fail("wait ran out");
        wrap_up();
      end
    end
    repeat (3) @(posedge CLK);
  endtask
  // monitor: oldest note against each read slot and each send
  always @(posedge CLK) begin
    rd_d <= RD;
    if (rd_d && rd_q.size() == 0) fail("read without note");
    else if (rd_d) cmp_rd(RDATA, rd_q.pop_front());
    if (TX_START === 1'b1 && tx_q.size() == 0) fail("send without note");
    else if (TX_START === 1'b1) cmp_tx({TX_PORT, TX_SLAVE, TX_REG, TX_UNIT_ID, TX_EXC_NUM,
      TX_VALUE, TX_TIME, TX_DATE}, tx_q.pop_front());
  end
  // ============================================================
  // main sequence
  initial begin
    s = $urandom(32'h6bd1);
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    rd(`ERBM_A_UNIT_ID, 16'h0000);
    rd(`ERBM_A_DEST_PORT, 16'h0000);
    rd(`ERBM_A_ERR_STATUS, 16'h0000);
    rd(`ERBM_A_SLAVE_ADDR, 16'h0000);
    rd(`ERBM_A_START_REG, 16'h0001);
    rd(`ERBM_A_TRY_COUNT, 16'h0000);
    rd(`ERBM_A_TIMEOUT_MS, 16'h0bb8);
    rd(`ERBM_A_QUIET_MS, 16'h03e8);
    rd(`ERBM_A_HOLD_MS, 16'h0064);
    rd(8'h3f, 16'h0000);
    wr(`ERBM_A_UNIT_ID, 16'h2710);
    cfg(2'h1, 8'hff, 14'h0000);
    rd(`ERBM_A_UNIT_ID, 16'h270f);
    rd(`ERBM_A_SLAVE_ADDR, 16'h00f7);
    rd(`ERBM_A_START_REG, 16'h0001);
    $display("test reset values and limits done");
    // short quiet and hold keep the run brief; timeout of 2 ms outlasts every reply
    wr(`ERBM_A_UNIT_ID, {2'h0, unit});
    wr(`ERBM_A_QUIET_MS, 16'h0000);
    wr(`ERBM_A_HOLD_MS, 16'h0000);
    wr(`ERBM_A_TIMEOUT_MS, 16'h0002);
    fire(3, 0);
    rd(`ERBM_A_EXC_NUM, 16'h0000);
    wr(`ERBM_A_TRIG_CFG_OK, 16'h0001);
    wr(`ERBM_A_UNIT_ID, 16'h0000);
    fire(4, 0);
    rd(`ERBM_A_EXC_NUM, 16'h0000);
    wr(`ERBM_A_UNIT_ID, {2'h0, unit});
    cfg(2'h0, 8'h11, 14'h0010);
    fire(7, 0);
    rd(`ERBM_A_EXC_NUM, 16'h0008);
    rd(`ERBM_A_EXC_VALUE, WATCH_VALUE);
    rd(`ERBM_A_PENDING, 16'h0000);
    $display("test gating done");
    for (i = 1; i < 4; i++) begin
      cfg(i[1:0], 8'($urandom_range(247, 1)), 14'($urandom_range(9999, 1)));
      code      <= 7'($urandom_range(99, 0));
      delay     <= 8'($urandom_range(200, 1));
      LINK_BUSY <= (i == 1);
      s = n_ans;
      fire($urandom_range(31, 0), 1);
      repeat (100) @(posedge CLK);
      LINK_BUSY <= 1'b0;
      wait_until(0, s + 1);
      rd(`ERBM_A_ERR_STATUS, {9'h0, code});
    end
    $display("test sends on each port done");
    delay <= 8'h14;
    for (i = 1; i < 4; i++) begin
      mode <= 3'(i);
      s = n_ans;
      fire(i + 10, (i < 3) ? 2 : 1);
      wait_until(0, s + 1);
      mode <= 3'h0;
      code <= 7'h00;
      rd(`ERBM_A_ERR_STATUS, {9'h0, (i == 1) ? `ERBM_ST_UNRECOG : (i == 2) ?
        `ERBM_ST_UNEXP : `ERBM_ST_STOPPED});
      if (i < 3) begin
        wait_until(0, s + 2);
        rd(`ERBM_A_ERR_STATUS, 16'h0000);
      end
    end
    $display("test reply faults done");
    cfg(2'h2, 8'h00, 14'h270f);
    wr(`ERBM_A_TRY_COUNT, 16'h0001);
    fire(31, 1);
    wait_until(1, 0);
    repeat (300) @(posedge CLK);
    rd(`ERBM_A_ERR_STATUS, 16'h0000);
    rd(`ERBM_A_PENDING, 16'h0000);
    $display("test broadcast done");
    cfg(2'h3, 8'h2a, 14'h0064);
    wr(`ERBM_A_TIMEOUT_MS, 16'h0001);
    MODEM_ATTACHED <= 1'b1;
    MORE_NUMBERS   <= 1'b1;
    mode           <= 3'h4;
    fire(0, 2);
    wait_until(2, 0);
    rd(`ERBM_A_ERR_STATUS, {9'h0, `ERBM_ST_NOCONN});
    MORE_NUMBERS <= 1'b0;
    repeat (41000) @(posedge CLK);
    rd(`ERBM_A_ERR_STATUS, {9'h0, `ERBM_ST_ALLFAIL});
    rd(`ERBM_A_EXC_NUM, 16'h0001);
    rd(`ERBM_A_PENDING, 16'h0000);
    $display("test timeout and redial done");
    repeat (3) @(posedge CLK);
    wrap_up();
  end
endmodule // erbm_engine_tb
`default_nettype wire

//--- erbm_far_end.sv
// model of the serial driver and remote slave answering report writes
`default_nettype none
module erbm_far_end (
  input wire logic       CLK,
  input wire logic       NRST,
  input wire logic       TX_START,
  input wire logic [7:0] TX_SLAVE,
  input wire logic [2:0] mode,
  input wire logic [6:0] code,
  input wire logic [7:0] delay,
  output logic           TX_READY,
  output logic           RX_DONE,
  output logic           RX_OK,
  output logic           RX_UNEXPECTED,
  output logic [6:0]     RX_EXC_CODE,
  output logic           DRV_STOP,
  output int             n_ans
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy_r;
  logic [7:0] cnt_r;
  // driver refuses new sends while a reply is outstanding
  assign TX_READY = !busy_r;
  // ============================================================
  // reply timing; mode 0 good, 1 malformed, 2 unexpected, 3 driver stop, 4 silent
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      busy_r        <= 1'b0;
      cnt_r         <= 8'h00;
      RX_DONE       <= 1'b0;
      DRV_STOP      <= 1'b0;
      RX_OK         <= 1'b0;
      RX_UNEXPECTED <= 1'b1;
      RX_EXC_CODE   <= 7'h55;
      n_ans         <= 0;
    end else begin
      // qualifiers wander outside the reply so stale values cannot pass
      RX_DONE       <= 1'b0;
      DRV_STOP      <= 1'b0;
      RX_OK         <= ~RX_OK;
      RX_UNEXPECTED <= ~RX_UNEXPECTED;
      RX_EXC_CODE   <= ~RX_EXC_CODE;
      if (TX_START && TX_SLAVE != 8'h00) begin // broadcast never answered
        busy_r <= 1'b1;
        cnt_r  <= delay;
      end else if (busy_r && cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        n_ans  <= n_ans + 1;
        if (mode == 3'h3) begin
          DRV_STOP <= 1'b1;
        end else if (mode != 3'h4) begin
          RX_DONE       <= 1'b1;
          RX_OK         <= (mode != 3'h1);
          RX_UNEXPECTED <= (mode == 3'h2);
          RX_EXC_CODE   <= code;
        end
      end
    end
  end
endmodule // erbm_far_end
`default_nettype wire

//--- erbm_map.vh
// register offsets, reset values and timing counts of the exception report engine
`ifndef ERBM_MAP_VH
`define ERBM_MAP_VH
// ============================================================
// register offsets (8-bit address)
`define ERBM_A_UNIT_ID      8'h00
`define ERBM_A_DEST_PORT    8'h01
`define ERBM_A_ERR_STATUS   8'h02
`define ERBM_A_SLAVE_ADDR   8'h03
`define ERBM_A_START_REG    8'h04
`define ERBM_A_TRY_COUNT    8'h05
`define ERBM_A_TIMEOUT_MS   8'h06
`define ERBM_A_QUIET_MS     8'h07
`define ERBM_A_HOLD_MS      8'h08
`define ERBM_A_TRIG_CFG_OK  8'h09
`define ERBM_A_EXC_NUM      8'h0a
`define ERBM_A_EXC_VALUE    8'h0b
`define ERBM_A_EXC_TIME     8'h0c
`define ERBM_A_EXC_DATE     8'h0d
`define ERBM_A_PENDING      8'h0e
// ============================================================
// reset values, holding register base and setting limits
`define ERBM_RST_UNIT_ID    14'h0000
`define ERBM_RST_DEST       2'h0
`define ERBM_RST_STATUS     7'h00
`define ERBM_RST_SLAVE      8'h00
`define ERBM_RST_START      14'h0001
`define ERBM_RST_TRIES      14'h0000
`define ERBM_RST_TIMEOUT    14'h0bb8
`define ERBM_RST_QUIET      14'h03e8
`define ERBM_RST_HOLD       14'h0064
`define ERBM_HREG_BASE      16'h9c40
`define ERBM_SLAVE_MAX      8'hf7
`define ERBM_ID_MAX         14'h270f
// ============================================================
// status codes
`define ERBM_ST_OK          7'h00
`define ERBM_ST_NOCONN      7'h64
`define ERBM_ST_UNRECOG     7'h65
`define ERBM_ST_STOPPED     7'h66
`define ERBM_ST_TIMEOUT     7'h67
`define ERBM_ST_FAILTRY     7'h68
`define ERBM_ST_ALLFAIL     7'h69
`define ERBM_ST_UNEXP       7'h6a
// ============================================================
// timing: 1 ms at 40 MHz
`define ERBM_CLK_HZ         40000000
`define ERBM_MS_CYCLES      (`ERBM_CLK_HZ / 1000)
// divider reload, one less than the cycles in a millisecond
`define ERBM_MS_RELOAD      16'h9c3f
`endif
